// File: common/lalu_pkg.sv
`default_nettype none

package lalu_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned PC_W = 13;

  ////////////////////////////////////////////////////////////////////////////
  // Special-purpose register map.
  localparam logic [7:0] ADDR_IND_PTR_UPPER = 8'h04;
  localparam logic [7:0] ADDR_IND_PTR_LOWER = 8'h05;
  localparam logic [7:0] ADDR_STACK_PTR_UPPER = 8'h06;
  localparam logic [7:0] ADDR_STACK_PTR_LOWER = 8'h07;
  localparam logic [7:0] ADDR_PROG_COUNTER_LOW_ALIAS = 8'h09;
  localparam logic [7:0] ADDR_CPU_FLAGS = 8'h0B;
  localparam logic [7:0] ADDR_DATA_PTR_UPPER = 8'h0C;
  localparam logic [7:0] ADDR_DATA_PTR_LOWER = 8'h0D;

  localparam logic [7:0] DIRECT_MIN_ADDR = 8'h01;
  localparam logic [15:0] OFFSET_MIN_ADDR = 16'h0020;

  ////////////////////////////////////////////////////////////////////////////
  // Flags register fields.
  localparam int unsigned BIT_ARITH_OVF = 0;
  localparam int unsigned BIT_NIBBLE_OVF = 1;
  localparam int unsigned BIT_NULL = 2;
  localparam int unsigned BIT_SUPPLY_DIP = 3;
  localparam int unsigned BIT_TIMEOUT = 4;
  localparam int unsigned BIT_ROM_BANK_LO = 5;
  localparam int unsigned BIT_ROM_BANK_HI = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Operations, destination forms and addressing modes.
  typedef enum logic [2:0] {
    LALU_OP_AND,
    LALU_OP_OR,
    LALU_OP_XOR,
    LALU_OP_NOT,
    LALU_OP_JUMP
  } lalu_op_t;

  typedef enum logic [1:0] {
    LALU_FORM_TO_FILE,
    LALU_FORM_TO_ACC,
    LALU_FORM_IMM_TO_ACC
  } lalu_form_t;

  typedef enum logic [1:0] {
    LALU_MODE_DIRECT,
    LALU_MODE_INDIRECT,
    LALU_MODE_OFS_DATA,
    LALU_MODE_OFS_STACK
  } lalu_mode_t;

endpackage

`default_nettype wire

// File: hw/lalu_addr_gen.sv
`default_nettype none

module lalu_addr_gen (
  // Operand selection
  input wire lalu_pkg::lalu_mode_t mode_i,
  input wire logic [7:0] field_i,
  // Pointer values
  input wire logic [15:0] ind_ptr_i,
  input wire logic [15:0] data_ptr_i,
  input wire logic [15:0] stack_ptr_i,
  // Resolved location
  output logic [15:0] addr_o,
  output logic addr_ok_o
);

  logic [15:0] base;
  logic [16:0] sum;

  always_comb begin
    base = data_ptr_i;
    if (mode_i == lalu_pkg::LALU_MODE_OFS_STACK) begin
      base = stack_ptr_i;
    end
    // Offset is unsigned; a carry out of 16 bits is treated as out of range.
    sum = {1'b0, base} + {9'h000, field_i};
    unique case (mode_i)
      lalu_pkg::LALU_MODE_DIRECT: begin
        addr_o = {8'h00, field_i};
        addr_ok_o = (field_i >= lalu_pkg::DIRECT_MIN_ADDR);
      end
      lalu_pkg::LALU_MODE_INDIRECT: begin
        addr_o = ind_ptr_i;
        addr_ok_o = 1'b1;
      end
      lalu_pkg::LALU_MODE_OFS_DATA,
      lalu_pkg::LALU_MODE_OFS_STACK: begin
        addr_o = sum[15:0];
        addr_ok_o = !sum[16] && (sum[15:0] >= lalu_pkg::OFFSET_MIN_ADDR);
      end
    endcase
  end

endmodule

`default_nettype wire

// File: hw/lalu_core.sv
`default_nettype none

module lalu_core (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Instruction from the decoder
  input wire logic ins_valid_i,
  output logic ins_ready_o,
  input wire lalu_pkg::lalu_op_t ins_op_i,
  input wire lalu_pkg::lalu_form_t ins_form_i,
  input wire lalu_pkg::lalu_mode_t ins_mode_i,
  input wire logic [7:0] ins_field_i,
  input wire logic [7:0] imm_byte_i,
  input wire logic [12:0] jump_target_i,
  // Completion
  output logic done_o,
  output logic addr_err_o,
  // Data memory
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  // Supervisor events
  input wire logic supply_dip_set_i,
  input wire logic timeout_set_i,
  // Architectural state
  output logic [7:0] acc_o,
  output logic [7:0] cpu_flags_o,
  output logic [12:0] pc_o
);

  typedef enum logic [1:0] {
    LALU_ST_IDLE,
    LALU_ST_FETCH,
    LALU_ST_LOAD,
    LALU_ST_WRBK
  } lalu_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction sequencing.
  lalu_state_t state, next_state;
  lalu_pkg::lalu_op_t op_q, next_op_q;
  lalu_pkg::lalu_form_t form_q, next_form_q;
  logic [15:0] addr_q, next_addr_q;
  logic [7:0] imm_q, next_imm_q;
  logic [12:0] jump_q, next_jump_q;
  logic local_q, next_local_q;
  logic err_q, next_err_q;
  logic [7:0] res_q, next_res_q;
  logic null_q, next_null_q;

  // Architectural registers.
  logic [7:0] acc, next_acc;
  logic [7:0] cpu_flags, next_cpu_flags;
  logic [7:0] ind_ptr_upper, next_ind_ptr_upper;
  logic [7:0] ind_ptr_lower, next_ind_ptr_lower;
  logic [7:0] stack_ptr_upper, next_stack_ptr_upper;
  logic [7:0] stack_ptr_lower, next_stack_ptr_lower;
  logic [7:0] data_ptr_upper, next_data_ptr_upper;
  logic [7:0] data_ptr_lower, next_data_ptr_lower;
  logic [12:0] pc, next_pc;

  logic accept;
  logic [15:0] new_addr;
  logic new_addr_ok;
  logic new_local;
  logic [7:0] spr_rdata;
  logic [7:0] file_operand;
  logic [7:0] alu_result;
  logic alu_null;
  logic wb_active;
  logic wb_to_file;
  logic wb_local;

  lalu_addr_gen u_addr_gen (
    .mode_i(ins_mode_i),
    .field_i(ins_field_i),
    .ind_ptr_i({ind_ptr_upper, ind_ptr_lower}),
    .data_ptr_i({data_ptr_upper, data_ptr_lower}),
    .stack_ptr_i({stack_ptr_upper, stack_ptr_lower}),
    .addr_o(new_addr),
    .addr_ok_o(new_addr_ok)
  );

  lalu_logic_unit u_logic_unit (
    .op_i(op_q),
    .form_i(form_q),
    .acc_i(acc),
    .file_operand_i(file_operand),
    .imm_byte_i(imm_q),
    .result_o(alu_result),
    .null_o(alu_null)
  );

  assign ins_ready_o = (state == LALU_ST_IDLE);
  assign accept = ins_valid_i && ins_ready_o;

  ////////////////////////////////////////////////////////////////////////////
  // Special-purpose register decode and read path.
  always_comb begin
    new_local = 1'b0;
    if (new_addr[15:8] == 8'h00) begin
      case (new_addr[7:0])
        lalu_pkg::ADDR_IND_PTR_UPPER, lalu_pkg::ADDR_IND_PTR_LOWER,
        lalu_pkg::ADDR_STACK_PTR_UPPER, lalu_pkg::ADDR_STACK_PTR_LOWER,
        lalu_pkg::ADDR_PROG_COUNTER_LOW_ALIAS, lalu_pkg::ADDR_CPU_FLAGS,
        lalu_pkg::ADDR_DATA_PTR_UPPER, lalu_pkg::ADDR_DATA_PTR_LOWER: new_local = 1'b1;
        default: new_local = 1'b0;
      endcase
    end
  end

  always_comb begin
    case (addr_q[7:0])
      lalu_pkg::ADDR_IND_PTR_UPPER: spr_rdata = ind_ptr_upper;
      lalu_pkg::ADDR_IND_PTR_LOWER: spr_rdata = ind_ptr_lower;
      lalu_pkg::ADDR_STACK_PTR_UPPER: spr_rdata = stack_ptr_upper;
      lalu_pkg::ADDR_STACK_PTR_LOWER: spr_rdata = stack_ptr_lower;
      lalu_pkg::ADDR_PROG_COUNTER_LOW_ALIAS: spr_rdata = pc[7:0];
      lalu_pkg::ADDR_CPU_FLAGS: spr_rdata = cpu_flags;
      lalu_pkg::ADDR_DATA_PTR_UPPER: spr_rdata = data_ptr_upper;
      lalu_pkg::ADDR_DATA_PTR_LOWER: spr_rdata = data_ptr_lower;
      default: spr_rdata = 8'h00;
    endcase
    // Memory answers the cycle after the read strobe, which is the load cycle.
    file_operand = local_q ? spr_rdata : mem_rdata_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: idle, optional memory fetch, compute, write back.
  always_comb begin
    next_state = state;
    next_op_q = op_q;
    next_form_q = form_q;
    next_addr_q = addr_q;
    next_imm_q = imm_q;
    next_jump_q = jump_q;
    next_local_q = local_q;
    next_err_q = err_q;
    next_res_q = res_q;
    next_null_q = null_q;
    unique case (state)
      LALU_ST_IDLE: begin
        if (accept) begin
          next_op_q = ins_op_i;
          next_form_q = ins_form_i;
          next_addr_q = new_addr;
          next_imm_q = imm_byte_i;
          next_jump_q = jump_target_i;
          next_local_q = new_local;
          next_err_q = 1'b0;
          if (ins_op_i == lalu_pkg::LALU_OP_JUMP) begin
            next_state = LALU_ST_WRBK;
          end else if (ins_form_i == lalu_pkg::LALU_FORM_IMM_TO_ACC &&
                       ins_op_i != lalu_pkg::LALU_OP_NOT) begin
            next_state = LALU_ST_LOAD;
          end else if (!new_addr_ok) begin
            // Out-of-range operand: no access; only the program counter advances.
            next_err_q = 1'b1;
            next_state = LALU_ST_WRBK;
          end else if (new_local) begin
            next_state = LALU_ST_LOAD;
          end else begin
            next_state = LALU_ST_FETCH;
          end
        end
      end
      LALU_ST_FETCH: begin
        next_state = LALU_ST_LOAD;
      end
      LALU_ST_LOAD: begin
        next_res_q = alu_result;
        next_null_q = alu_null;
        next_state = LALU_ST_WRBK;
      end
      LALU_ST_WRBK: begin
        next_state = LALU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= LALU_ST_IDLE;
      op_q <= lalu_pkg::LALU_OP_AND;
      form_q <= lalu_pkg::LALU_FORM_TO_ACC;
      addr_q <= 16'h0000;
      imm_q <= 8'h00;
      jump_q <= 13'h0000;
      local_q <= 1'b0;
      err_q <= 1'b0;
      res_q <= 8'h00;
      null_q <= 1'b0;
    end else begin
      state <= next_state;
      op_q <= next_op_q;
      form_q <= next_form_q;
      addr_q <= next_addr_q;
      imm_q <= next_imm_q;
      jump_q <= next_jump_q;
      local_q <= next_local_q;
      err_q <= next_err_q;
      res_q <= next_res_q;
      null_q <= next_null_q;
    end
  end

  assign wb_active = (state == LALU_ST_WRBK) && !err_q && (op_q != lalu_pkg::LALU_OP_JUMP);
  assign wb_to_file = wb_active && (form_q == lalu_pkg::LALU_FORM_TO_FILE);
  assign wb_local = wb_to_file && local_q;

  assign mem_rd_o = (state == LALU_ST_FETCH);
  assign mem_wr_o = wb_to_file && !local_q;
  assign mem_addr_o = addr_q;
  assign mem_wdata_o = res_q;
  assign done_o = (state == LALU_ST_WRBK);
  assign addr_err_o = (state == LALU_ST_WRBK) && err_q;

  ////////////////////////////////////////////////////////////////////////////
  // Architectural registers.
  always_comb begin
    next_acc = acc;
    next_cpu_flags = cpu_flags;
    next_ind_ptr_upper = ind_ptr_upper;
    next_ind_ptr_lower = ind_ptr_lower;
    next_stack_ptr_upper = stack_ptr_upper;
    next_stack_ptr_lower = stack_ptr_lower;
    next_data_ptr_upper = data_ptr_upper;
    next_data_ptr_lower = data_ptr_lower;
    next_pc = pc;
    if (state == LALU_ST_WRBK) begin
      if (op_q == lalu_pkg::LALU_OP_JUMP) begin
        next_pc = jump_q;
      end else begin
        next_pc = pc + 13'h0001;
      end
    end
    if (wb_active && !wb_to_file) begin
      next_acc = res_q;
    end
    if (wb_local) begin
      case (addr_q[7:0])
        lalu_pkg::ADDR_IND_PTR_UPPER: next_ind_ptr_upper = res_q;
        lalu_pkg::ADDR_IND_PTR_LOWER: next_ind_ptr_lower = res_q;
        lalu_pkg::ADDR_STACK_PTR_UPPER: next_stack_ptr_upper = res_q;
        lalu_pkg::ADDR_STACK_PTR_LOWER: next_stack_ptr_lower = res_q;
        lalu_pkg::ADDR_PROG_COUNTER_LOW_ALIAS: next_pc = {pc[12:8], res_q};
        lalu_pkg::ADDR_CPU_FLAGS: next_cpu_flags = res_q;
        lalu_pkg::ADDR_DATA_PTR_UPPER: next_data_ptr_upper = res_q;
        lalu_pkg::ADDR_DATA_PTR_LOWER: next_data_ptr_lower = res_q;
        default: ;
      endcase
    end
    // The zero test wins over a value written into the flags themselves.
    if (wb_active) begin
      next_cpu_flags[lalu_pkg::BIT_NULL] = null_q;
    end
    // Supervisor events are never lost to a simultaneous software clear.
    if (supply_dip_set_i) begin
      next_cpu_flags[lalu_pkg::BIT_SUPPLY_DIP] = 1'b1;
    end
    if (timeout_set_i) begin
      next_cpu_flags[lalu_pkg::BIT_TIMEOUT] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc <= lalu_pkg::REG_RST;
      cpu_flags <= lalu_pkg::FLAGS_RST;
      ind_ptr_upper <= lalu_pkg::REG_RST;
      ind_ptr_lower <= lalu_pkg::REG_RST;
      stack_ptr_upper <= lalu_pkg::REG_RST;
      stack_ptr_lower <= lalu_pkg::REG_RST;
      data_ptr_upper <= lalu_pkg::REG_RST;
      data_ptr_lower <= lalu_pkg::REG_RST;
      pc <= lalu_pkg::PC_RST;
    end else begin
      acc <= next_acc;
      cpu_flags <= next_cpu_flags;
      ind_ptr_upper <= next_ind_ptr_upper;
      ind_ptr_lower <= next_ind_ptr_lower;
      stack_ptr_upper <= next_stack_ptr_upper;
      stack_ptr_lower <= next_stack_ptr_lower;
      data_ptr_upper <= next_data_ptr_upper;
      data_ptr_lower <= next_data_ptr_lower;
      pc <= next_pc;
    end
  end

  assign acc_o = acc;
  assign cpu_flags_o = cpu_flags;
  assign pc_o = pc;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_and_mem_result: assert property (
    (state == LALU_ST_LOAD && op_q == lalu_pkg::LALU_OP_AND && !local_q &&
     form_q != lalu_pkg::LALU_FORM_IMM_TO_ACC)
    |=> res_q == ($past(acc) & $past(mem_rdata_i)))
    else $error("AND result does not match accumulator and memory operand");

  a_xor_imm_result: assert property (
    (accept && ins_op_i == lalu_pkg::LALU_OP_XOR &&
     ins_form_i == lalu_pkg::LALU_FORM_IMM_TO_ACC)
    |=> ##1 res_q == ($past(acc) ^ $past(imm_byte_i, 2)))
    else $error("XOR with immediate byte gave a wrong result");

  a_not_mem_result: assert property (
    (state == LALU_ST_LOAD && op_q == lalu_pkg::LALU_OP_NOT && !local_q)
    |=> res_q == ~$past(mem_rdata_i))
    else $error("Complement result is not the inverted operand");

  a_or_to_acc: assert property (
    (wb_active && op_q == lalu_pkg::LALU_OP_OR && form_q != lalu_pkg::LALU_FORM_TO_FILE)
    |=> acc == $past(res_q))
    else $error("OR result did not reach the accumulator");

  a_null_tracks_zero: assert property (
    (state == LALU_ST_LOAD && op_q != lalu_pkg::LALU_OP_JUMP)
    |=> ##1 cpu_flags[lalu_pkg::BIT_NULL] == (res_q == 8'h00))
    else $error("Null bit does not reflect the zero test");

  a_ovf_bits_kept: assert property (
    (wb_active && !(wb_local && addr_q[7:0] == lalu_pkg::ADDR_CPU_FLAGS))
    |=> cpu_flags[1:0] == $past(cpu_flags[1:0]))
    else $error("Overflow bits changed by a logical operation");

  a_alias_moves_pc: assert property (
    (wb_local && addr_q[7:0] == lalu_pkg::ADDR_PROG_COUNTER_LOW_ALIAS)
    |=> pc[7:0] == $past(res_q) && pc[12:8] == $past(pc[12:8]))
    else $error("Alias write did not load the program counter low byte");

  a_jump_loads_pc: assert property (
    (accept && ins_op_i == lalu_pkg::LALU_OP_JUMP)
    |=> done_o ##1 pc == $past(jump_target_i, 2))
    else $error("Jump did not load its 13-bit target");

  a_direct_zero_refused: assert property (
    (accept && ins_op_i != lalu_pkg::LALU_OP_JUMP && ins_field_i == 8'h00 &&
     ins_mode_i == lalu_pkg::LALU_MODE_DIRECT &&
     ins_form_i != lalu_pkg::LALU_FORM_IMM_TO_ACC)
    |=> addr_err_o && !mem_rd_o && !mem_wr_o)
    else $error("Direct address zero was not refused");

  a_offset_floor: assert property (
    mem_rd_o |-> (mem_addr_o >= lalu_pkg::OFFSET_MIN_ADDR || mem_addr_o[15:8] == 8'h00))
    else $error("Offset access below the lowest legal address");

  a_flags_readable: assert property (
    (state == LALU_ST_LOAD && local_q && addr_q[7:0] == lalu_pkg::ADDR_CPU_FLAGS)
    |-> file_operand == cpu_flags)
    else $error("Flags register not seen at its direct address");

endmodule

`default_nettype wire

// File: hw/lalu_logic_unit.sv
`default_nettype none

module lalu_logic_unit (
  // Operation
  input wire lalu_pkg::lalu_op_t op_i,
  input wire lalu_pkg::lalu_form_t form_i,
  // Operands
  input wire logic [7:0] acc_i,
  input wire logic [7:0] file_operand_i,
  input wire logic [7:0] imm_byte_i,
  // Result
  output logic [7:0] result_o,
  output logic null_o
);

  logic [7:0] operand_b;

  always_comb begin
    operand_b = file_operand_i;
    if (form_i == lalu_pkg::LALU_FORM_IMM_TO_ACC) begin
      operand_b = imm_byte_i;
    end
    case (op_i)
      lalu_pkg::LALU_OP_AND: result_o = acc_i & operand_b;
      lalu_pkg::LALU_OP_OR: result_o = acc_i | operand_b;
      lalu_pkg::LALU_OP_XOR: result_o = acc_i ^ operand_b;
      lalu_pkg::LALU_OP_NOT: result_o = ~file_operand_i;
      default: result_o = 8'h00;
    endcase
    null_o = (result_o == 8'h00);
  end

endmodule

`default_nettype wire

// File: test/lalu_mem_model.sv
`default_nettype none

module lalu_mem_model (
  // Clock
  input wire logic mclk_i,
  // Data memory port of the core
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [logic [15:0]];

  initial mem_rdata_o = 8'h00;

  // Unwritten cells hold a pattern derived from the address.
  function automatic logic [7:0] peek(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
  endfunction

  // Read data is good only in the cycle after the strobe.
  // At any other time it toggles, so a late sample reads garbage.
  always @(posedge mclk_i) begin
    if (mem_rd_i === 1'b1) begin
      mem_rdata_o <= peek(mem_addr_i);
    end else begin
      mem_rdata_o <= ~mem_rdata_o;
    end
    if (mem_wr_i === 1'b1) begin
      mem[mem_addr_i] = mem_wdata_i;
    end
  end
endmodule

`default_nettype wire

// File: test/tb.sv
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [7:0] acc, flags, wdata;
    logic [12:0] pc;
    logic [15:0] addr;
    logic err, rd, wr;
    int lat, t0;
  } lalu_note_t;

  logic mclk, rst_n, ins_valid, ins_ready, done, addr_err, mem_rd, mem_wr, dip_set, tmo_set;
  lalu_pkg::lalu_op_t op;
  lalu_pkg::lalu_form_t form;
  lalu_pkg::lalu_mode_t mode;
  logic [7:0] field, imm, rdata, wdata, acc, flags;
  logic [15:0] maddr;
  logic [12:0] jt, pc;
  logic [31:0] seed;
  logic [7:0] r_acc, r_flags;
  logic [12:0] r_pc;
  logic [7:0] r_reg [256];
  logic [7:0] r_mem [logic [15:0]];
  logic saw_rd;
  int n_fail, checks, cyc, i;
  lalu_note_t q [$];
  lalu_note_t mon;

  lalu_core i_lalu_core (.mclk_i(mclk), .rst_n_i(rst_n), .ins_valid_i(ins_valid),
    .ins_ready_o(ins_ready), .ins_op_i(op), .ins_form_i(form), .ins_mode_i(mode),
    .ins_field_i(field), .imm_byte_i(imm), .jump_target_i(jt), .done_o(done),
    .addr_err_o(addr_err), .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .mem_addr_o(maddr),
    .mem_wdata_o(wdata), .mem_rdata_i(rdata), .supply_dip_set_i(dip_set),
    .timeout_set_i(tmo_set), .acc_o(acc), .cpu_flags_o(flags), .pc_o(pc));

  lalu_mem_model i_lalu_mem_model (.mclk_i(mclk), .mem_rd_i(mem_rd), .mem_wr_i(mem_wr),
    .mem_addr_i(maddr), .mem_wdata_i(wdata), .mem_rdata_o(rdata));

  always #12.5 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc <= cyc + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  function automatic logic [7:0] peek(input logic [15:0] a);
    return r_mem.exists(a) ? r_mem[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reference step, then the request is offered until the core takes it.
  task automatic issue(input int o, input int f, input int m, input logic [7:0] fl,
                       input logic [7:0] im, input logic [12:0] j);
    lalu_note_t n;
    logic [16:0] sum;
    logic [7:0] x, res, a;
    logic loc, imf;
    int k;
    n.wr = 1'b0;
    n.wdata = 8'h00;
    n.err = 1'b0;
    imf = (f == 2) && (o != 3);
    case (m)
      0: sum = {9'h000, fl};
      1: sum = {1'b0, r_reg[4], r_reg[5]};
      2: sum = {1'b0, r_reg[12], r_reg[13]} + 17'(fl);
      default: sum = {1'b0, r_reg[6], r_reg[7]} + 17'(fl);
    endcase
    n.addr = sum[15:0];
    a = sum[7:0];
    loc = (sum[15:8] == 8'h00) && (a inside {8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0B,
                                             8'h0C, 8'h0D});
    if (!imf && o != 4) begin
      n.err = (m == 0) ? (fl == 8'h00) : (m > 1 && (sum[16] || sum < 17'h00020));
    end
    n.lat = (o == 4 || n.err) ? 1 : (imf || loc) ? 2 : 3;
    n.rd = !n.err && !imf && !loc && o != 4;
    x = imf ? im : !loc ? peek(n.addr) : a == 8'h0B ? r_flags : a == 8'h09 ? r_pc[7:0] : r_reg[a];
    case (o)
      0: res = r_acc & x;
      1: res = r_acc | x;
      2: res = r_acc ^ x;
      default: res = ~x;
    endcase
    if (o == 4) begin
      r_pc = j;
    end else if (n.err) begin
      r_pc = r_pc + 13'h0001;
    end else begin
      r_flags[2] = (res == 8'h00);
      r_pc = r_pc + 13'h0001;
      if (f != 0) begin
        r_acc = res;
      end else if (!loc) begin
        n.wr = 1'b1;
        n.wdata = res;
        r_mem[n.addr] = res;
      end else if (a == 8'h0B) begin
        r_flags = {res[7:3], res == 8'h00, res[1:0]};
      end else if (a == 8'h09) begin
        r_pc = {r_pc[12:8] - 5'(r_pc[7:0] == 8'h00), res};
      end else begin
        r_reg[a] = res;
      end
    end
    n.acc = r_acc;
    n.flags = r_flags;
    n.pc = r_pc;
    op = lalu_pkg::lalu_op_t'(o);
    form = lalu_pkg::lalu_form_t'(f);
    mode = lalu_pkg::lalu_mode_t'(m);
    field = fl;
    imm = im;
    jt = j;
    ins_valid = 1'b1;
    for (k = 0; k < 20 && ins_ready !== 1'b1; k++) begin
      @(posedge mclk) #1;
    end
    if (k == 20) begin
      n_fail++;
      stop_test();
    end
    @(posedge mclk);
    n.t0 = cyc;
    q.push_back(n);
    #1 ins_valid = 1'b0;
    // Let an edge pass so that the next call never lowers and raises valid at once.
    @(posedge mclk) #1;
  endtask

  // Clear, then OR the value in, so the old contents never matter.
  task automatic setreg(input logic [7:0] a, input logic [7:0] v);
    issue(0, 2, 0, 8'h00, 8'h00, 13'h0000);
    issue(0, 0, 0, a, 8'h00, 13'h0000);
    issue(1, 2, 0, 8'h00, v, 13'h0000);
    issue(1, 0, 0, a, 8'h00, 13'h0000);
  endtask

  task automatic drain();
    int k;
    for (k = 0; k < 40 && q.size() > 0; k++) begin
      @(posedge mclk) #1;
    end
    if (k == 40) begin
      n_fail++;
      stop_test();
    end
    @(posedge mclk) #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (rst_n === 1'b1 && mem_rd === 1'b1) begin
      saw_rd = 1'b1;
      chk(maddr, (q.size() > 0) ? q[0].addr : 16'h0000, "read address");
    end
    if (rst_n === 1'b1 && done === 1'b1) begin
      chk(q.size() > 0, 1, "unexpected done");
      mon = q.pop_front();
      chk(cyc - mon.t0, mon.lat, "latency");
      chk(addr_err, mon.err, "address error");
      chk(saw_rd, mon.rd, "read strobe");
      chk(mem_wr, mon.wr, "write strobe");
      if (mon.wr === 1'b1) begin
        chk({maddr, wdata}, {mon.addr, mon.wdata}, "write");
      end
      saw_rd = 1'b0;
      @(negedge mclk);
      chk(acc, mon.acc, "accumulator");
      chk(flags, mon.flags, "flags");
      chk(pc, mon.pc, "program counter");
    end
  end

  initial begin
    {mclk, rst_n, ins_valid, dip_set, tmo_set, saw_rd} = 6'h00;
    op = lalu_pkg::LALU_OP_AND;
    form = lalu_pkg::LALU_FORM_TO_FILE;
    mode = lalu_pkg::LALU_MODE_DIRECT;
    {field, imm, jt} = '0;
    {r_acc, r_flags, r_pc} = '0;
    r_reg = '{default: 8'h00};
    seed = 32'hEA1DAC1A;
    {n_fail, checks, cyc} = '0;
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk({ins_ready, pc, flags, acc}, {1'b1, 29'h00000000}, "reset state");
    for (i = 0; i < 36; i++) begin
      issue(i % 4, (i / 4) % 3, 0, 8'h20 | rnd(), rnd(), 13'h0000);
    end
    issue(0, 2, 0, 8'h00, 8'h00, 13'h0000);
    issue(2, 0, 0, 8'hFF, 8'h00, 13'h0000);
    issue(1, 0, 0, 8'h00, 8'h00, 13'h0000);
    issue(1, 2, 0, 8'h00, 8'hC3, 13'h0000);
    setreg(8'h04, 8'h12);
    setreg(8'h05, 8'h34);
    issue(2, 1, 1, rnd(), 8'h00, 13'h0000);
    setreg(8'h0C, 8'h01);
    setreg(8'h0D, 8'h00);
    issue(3, 0, 2, 8'hFF, 8'h00, 13'h0000);
    setreg(8'h06, 8'h00);
    setreg(8'h07, 8'h10);
    issue(3, 1, 3, 8'h0F, 8'h00, 13'h0000);
    issue(3, 0, 3, 8'h10, 8'h00, 13'h0000);
    setreg(8'h06, 8'hFF);
    setreg(8'h07, 8'hF0);
    issue(0, 1, 3, 8'h20, 8'h00, 13'h0000);
    setreg(8'h04, 8'h00);
    setreg(8'h05, 8'h0B);
    issue(1, 1, 1, 8'h00, 8'h00, 13'h0000);
    setreg(8'h0B, 8'h03);
    drain();
    dip_set = 1'b1;
    @(posedge mclk) #1;
    dip_set = 1'b0;
    tmo_set = 1'b1;
    @(posedge mclk) #1;
    tmo_set = 1'b0;
    r_flags = r_flags | 8'h18;
    issue(2, 2, 0, 8'h00, 8'hFF, 13'h0000);
    issue(1, 1, 0, 8'h0B, 8'h00, 13'h0000);
    issue(4, 0, 0, 8'h00, 8'h00, 13'({rnd(), rnd()}));
    setreg(8'h09, 8'h5C);
    drain();
    stop_test();
  end
endmodule

`default_nettype wire
